// file: adcpr_pkg.sv
package adcpr_pkg;
  localparam int ADCPR_ADDR_W = 8;
  localparam int ADCPR_DATA_W = 8;
  localparam int ADCPR_NUM_CH = 2;
  localparam int ADCPR_FIELD_W = 3;

  // Register offsets.
  localparam logic [7:0] OFF_CHAN_SEL = 8'h05;
  localparam logic [7:0] OFF_POWER = 8'h08;
  localparam logic [7:0] OFF_CLK_GLOBAL = 8'h09;
  localparam logic [7:0] OFF_PLL_STATUS = 8'h0A;
  localparam logic [7:0] OFF_CLK_DIV = 8'h0B;
  localparam logic [7:0] OFF_TRANSFER = 8'hFF;

  // Reset values.
  localparam logic [7:0] RST_CHAN_SEL = 8'h03;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_CLK_GLOBAL = 8'h01;
  localparam logic [7:0] RST_PLL_STATUS = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_TRANSFER = 8'h00;

  // Implemented bits of each register; all others read as zero.
  localparam logic [7:0] MASK_CHAN_SEL = 8'h03;
  localparam logic [7:0] MASK_POWER = 8'h23;
  localparam logic [7:0] MASK_CLK_GLOBAL = 8'h01;
  localparam logic [7:0] MASK_CLK_DIV = 8'h3F;

  // Field positions.
  localparam int POS_TRANSFER = 0;
  localparam int POS_PMODE = 0;
  localparam int POS_PIN_FUNC = 5;
  localparam int POS_DUTY = 0;
  localparam int POS_LOCK = 7;
  localparam int POS_DIV = 0;
  localparam int POS_PHASE = 3;

  // Internal power mode codes.
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_POWER_DOWN = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
endpackage

// file: adcpr_chan_regs.sv
`timescale 1ns/1ps
module adcpr_chan_regs (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register access
  input wire logic write_in,
  input wire logic [adcpr_pkg::ADCPR_DATA_W-1:0] wdata_in,
  input wire logic transfer_in,
  // Stored copies
  output logic [adcpr_pkg::ADCPR_DATA_W-1:0] shadow_out,
  output logic [adcpr_pkg::ADCPR_DATA_W-1:0] active_out
);
  import adcpr_pkg::*;

  logic [ADCPR_DATA_W-1:0] shadow_reg;
  logic [ADCPR_DATA_W-1:0] active_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shadow_reg <= RST_POWER;
    end else if (write_in) begin
      shadow_reg <= wdata_in & MASK_POWER; // R12
    end
  end

  // The active copy only moves on a transfer, so mode changes land together.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_reg <= RST_POWER;
    end else if (transfer_in) begin
      active_reg <= shadow_reg; // R3
    end
  end

  assign shadow_out = shadow_reg;
  assign active_out = active_reg;
endmodule

// file: adcpr_clk_div.sv
`timescale 1ns/1ps
module adcpr_clk_div #(
  parameter int FIELD_W = adcpr_pkg::ADCPR_FIELD_W
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Settings
  input wire logic [FIELD_W-1:0] div_code_in,
  input wire logic [FIELD_W-1:0] phase_code_in,
  // Divided clock tick
  output logic tick_out
);
  localparam int TAPS = (1 << FIELD_W) - 1;

  logic [FIELD_W-1:0] count_reg;
  logic [TAPS-1:0] delay_reg;
  logic tick_reg;
  logic base_tick;

  assign base_tick = (count_reg == '0);

  // Comparing with >= lets a smaller ratio take hold without a long wrap.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
    end else if (count_reg >= div_code_in) begin
      count_reg <= '0; // R9
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      delay_reg <= '0;
    end else begin
      delay_reg <= {delay_reg[TAPS-2:0], base_tick};
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_reg <= 1'b0;
    end else if (phase_code_in == '0) begin
      tick_reg <= base_tick; // R10
    end else begin
      tick_reg <= delay_reg[phase_code_in - 1'b1]; // R10
    end
  end

  assign tick_out = tick_reg;
endmodule

// file: adcpr_regs.sv
// How it works
// R1: Channel select holds A in bit 0, B in bit 1; reset selects both.
// R2: With both selected, reads return channel A and writes update both channels.
// R3: Writing transfer bit 0 copies all shadow registers into active ones together.
// R4: Shadowed writes stay inert until transfer; the transfer bit then clears itself.
// R5: Per-channel power mode: 00 normal, 01 power-down, 10 standby, 11 reserved.
// R6: Per-channel pin function bit: 0 pin powers down, 1 pin gives standby.
// R7: Global clock bit 0 enables the duty corrector; it is set after reset.
// R8: PLL status shows lock in bit 7, ignores writes, reads zero after reset.
// R9: Three-bit divide code divides the input clock by code plus one.
// R10: Three-bit phase code delays the divided clock by that many cycles.
// R11: Any nonzero divide code forces the duty corrector on.
// R12: Open bits read as zero and ignore written values.
`timescale 1ns/1ps
module adcpr_regs (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port from the serial control port
  input wire logic [adcpr_pkg::ADCPR_ADDR_W-1:0] reg_addr_in,
  input wire logic [adcpr_pkg::ADCPR_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [adcpr_pkg::ADCPR_DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Device status and pins
  input wire logic pll_locked_in,
  input wire logic power_down_pin_in,
  // Active settings
  output logic [1:0] chan_a_power_state_out,
  output logic [1:0] chan_b_power_state_out,
  output logic clock_duty_corrector_on_out,
  output logic [adcpr_pkg::ADCPR_FIELD_W-1:0] clock_div_code_out,
  output logic [adcpr_pkg::ADCPR_FIELD_W-1:0] clock_phase_code_out,
  output logic divided_clock_tick_out
);
  import adcpr_pkg::*;

  logic [ADCPR_DATA_W-1:0] chan_sel_reg;
  logic [ADCPR_DATA_W-1:0] clk_global_shadow_reg;
  logic [ADCPR_DATA_W-1:0] clk_global_active_reg;
  logic [ADCPR_DATA_W-1:0] clk_div_shadow_reg;
  logic [ADCPR_DATA_W-1:0] clk_div_active_reg;
  logic [ADCPR_DATA_W-1:0] pll_status_reg;
  logic transfer_reg;
  logic [ADCPR_DATA_W-1:0] rdata_reg;
  logic [ADCPR_DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic [1:0] power_state_reg [ADCPR_NUM_CH];
  logic duty_on_reg;
  logic [ADCPR_DATA_W-1:0] power_shadow [ADCPR_NUM_CH];
  logic [ADCPR_DATA_W-1:0] power_active [ADCPR_NUM_CH];
  logic wr_chan_sel;
  logic wr_power;
  logic wr_clk_global;
  logic wr_clk_div;
  logic wr_transfer;

  assign wr_chan_sel = reg_write_in && (reg_addr_in == OFF_CHAN_SEL);
  assign wr_power = reg_write_in && (reg_addr_in == OFF_POWER);
  assign wr_clk_global = reg_write_in && (reg_addr_in == OFF_CLK_GLOBAL);
  assign wr_clk_div = reg_write_in && (reg_addr_in == OFF_CLK_DIV);
  assign wr_transfer = reg_write_in && (reg_addr_in == OFF_TRANSFER);

  // Channel select is not shadowed: it steers the very next local write.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chan_sel_reg <= RST_CHAN_SEL; // R1
    end else if (wr_chan_sel) begin
      chan_sel_reg <= reg_wdata_in & MASK_CHAN_SEL; // R1 R12
    end
  end

  // The transfer bit lives one cycle; a new write in that cycle re-arms it.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      transfer_reg <= 1'b0;
    end else if (wr_transfer && reg_wdata_in[POS_TRANSFER]) begin
      transfer_reg <= 1'b1; // R3
    end else begin
      transfer_reg <= 1'b0; // R4
    end
  end

  // One copy of the power register per channel, steered by channel select.
  for (genvar ch = 0; ch < ADCPR_NUM_CH; ch++) begin : g_chan
    adcpr_chan_regs u_chan (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .write_in(wr_power && chan_sel_reg[ch]), // R2
      .wdata_in(reg_wdata_in),
      .transfer_in(transfer_reg),
      .shadow_out(power_shadow[ch]),
      .active_out(power_active[ch])
    );

    // The pin overrides the internal mode; reserved code 11 is run as normal.
    always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
        power_state_reg[ch] <= PM_NORMAL;
      end else if (power_down_pin_in) begin
        power_state_reg[ch] <= power_active[ch][POS_PIN_FUNC] ? PM_STANDBY
                                                               : PM_POWER_DOWN; // R6
      end else begin
        unique case (power_active[ch][POS_PMODE +: 2])
          PM_POWER_DOWN: power_state_reg[ch] <= PM_POWER_DOWN; // R5
          PM_STANDBY: power_state_reg[ch] <= PM_STANDBY; // R5
          default: power_state_reg[ch] <= PM_NORMAL; // R5
        endcase
      end
    end
  end

  // Global clock and divide settings: written to shadows, moved on transfer.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_global_shadow_reg <= RST_CLK_GLOBAL; // R7
    end else if (wr_clk_global) begin
      clk_global_shadow_reg <= reg_wdata_in & MASK_CLK_GLOBAL; // R12
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_div_shadow_reg <= RST_CLK_DIV;
    end else if (wr_clk_div) begin
      clk_div_shadow_reg <= reg_wdata_in & MASK_CLK_DIV; // R12
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_global_active_reg <= RST_CLK_GLOBAL; // R7
      clk_div_active_reg <= RST_CLK_DIV;
    end else if (transfer_reg) begin
      clk_global_active_reg <= clk_global_shadow_reg; // R3 R4
      clk_div_active_reg <= clk_div_shadow_reg; // R3 R4
    end
  end

  // The corrector is forced on because a divided clock loses its duty cycle.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      duty_on_reg <= RST_CLK_GLOBAL[POS_DUTY];
    end else begin
      duty_on_reg <= clk_global_active_reg[POS_DUTY] // R7
        || (clk_div_active_reg[POS_DIV +: ADCPR_FIELD_W] != '0); // R11
    end
  end

  // Lock is sampled every cycle; the register has no write path at all.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_status_reg <= RST_PLL_STATUS; // R8
    end else begin
      pll_status_reg <= 8'h00;
      pll_status_reg[POS_LOCK] <= pll_locked_in; // R8
    end
  end

  adcpr_clk_div #(
    .FIELD_W(ADCPR_FIELD_W)
  ) u_div (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .div_code_in(clk_div_active_reg[POS_DIV +: ADCPR_FIELD_W]), // R9
    .phase_code_in(clk_div_active_reg[POS_PHASE +: ADCPR_FIELD_W]), // R10
    .tick_out(divided_clock_tick_out)
  );

  // Reads show the pending shadow values, which is what software last wrote.
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr_in)
      OFF_CHAN_SEL: rdata_next = chan_sel_reg;
      OFF_POWER: begin
        if (chan_sel_reg[0] || !chan_sel_reg[1]) begin
          rdata_next = power_shadow[0]; // R2
        end else begin
          rdata_next = power_shadow[1];
        end
      end
      OFF_CLK_GLOBAL: rdata_next = clk_global_shadow_reg;
      OFF_PLL_STATUS: rdata_next = pll_status_reg; // R8
      OFF_CLK_DIV: rdata_next = clk_div_shadow_reg;
      OFF_TRANSFER: rdata_next = {7'h00, transfer_reg};
      default: rdata_next = 8'h00; // R12
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_read_in;
      if (reg_read_in) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign chan_a_power_state_out = power_state_reg[0];
  assign chan_b_power_state_out = power_state_reg[1];
  assign clock_duty_corrector_on_out = duty_on_reg;
  assign clock_div_code_out = clk_div_active_reg[POS_DIV +: ADCPR_FIELD_W];
  assign clock_phase_code_out = clk_div_active_reg[POS_PHASE +: ADCPR_FIELD_W];
endmodule

// file: adcpr_host.sv
`timescale 1ns/1ps
module adcpr_host (
  // Clock
  input wire logic clock_in,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end
  // One strobe per access; released lines show the inverse so stale values cannot match.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_write_out <= wr;
    reg_read_out <= !wr;
    @(posedge clock_in);
    reg_write_out <= 1'b0;
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
endmodule

// file: adcpr_regs_sva.sv
`timescale 1ns/1ps
module adcpr_regs_sva
  import adcpr_pkg::*;
(
  // Watched ports
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic pll_locked_in,
  input wire logic power_down_pin_in,
  input wire logic [1:0] chan_a_power_state_out,
  input wire logic clock_duty_corrector_on_out,
  input wire logic [2:0] clock_div_code_out,
  input wire logic [2:0] clock_phase_code_out,
  input wire logic divided_clock_tick_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] div_shadow_reg;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_shadow_reg <= RST_CLK_DIV;
    end else if (reg_write_in && reg_addr_in == OFF_CLK_DIV) begin
      div_shadow_reg <= reg_wdata_in;
    end
  end
  read_answer_a: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read gave no answer");
  pll_read_a: assert property (reg_read_in && reg_addr_in == OFF_PLL_STATUS && $past(resetn_in)
    |=> reg_rdata_out == {$past(pll_locked_in, 2), 7'h00}) else $error("pll status wrong");
  open_bits_a: assert property (reg_read_in && reg_addr_in == OFF_CHAN_SEL
    |=> reg_rdata_out[7:2] == 6'h00) else $error("open bits not zero");
  duty_forced_a: assert property (clock_div_code_out != 3'h0 && $past(clock_div_code_out) != 3'h0
    |-> clock_duty_corrector_on_out) else $error("duty corrector not forced");
  tick_div1_a: assert property (divided_clock_tick_out && clock_div_code_out == 3'h0
    && $past(clock_div_code_out) == 3'h0 |=> divided_clock_tick_out) else $error("div1 tick");
  tick_div4_a: assert property (divided_clock_tick_out && clock_div_code_out == 3'h3
    && $past(clock_div_code_out, 16) == 3'h3 |-> $past(divided_clock_tick_out, 4)
    && !$past(divided_clock_tick_out, 1) && !$past(divided_clock_tick_out, 2)
    && !$past(divided_clock_tick_out, 3)) else $error("div4 tick period");
  pin_power_a: assert property (power_down_pin_in |=> chan_a_power_state_out != PM_NORMAL)
    else $error("pin ignored");
  shadow_inert_a: assert property (reg_write_in && reg_addr_in == OFF_CLK_DIV
    |=> $stable(clock_div_code_out) [*3]) else $error("shadow write took effect");
  transfer_apply_a: assert property (reg_write_in && reg_addr_in == OFF_TRANSFER
    && reg_wdata_in[0] |=> ##1 {clock_phase_code_out, clock_div_code_out}
    == $past(div_shadow_reg[5:0])) else $error("transfer not applied");
  transfer_c: cover property (reg_write_in && reg_addr_in == OFF_TRANSFER);
  pll_c: cover property (reg_read_in && reg_addr_in == OFF_PLL_STATUS ##1 reg_rdata_out[7]);
  pin_c: cover property ($rose(power_down_pin_in));
endmodule
bind adcpr_regs adcpr_regs_sva i_adcpr_regs_sva (.*);

// file: adcpr_regs_bench.sv
`timescale 1ns/1ps
module adcpr_regs_bench;
  import adcpr_pkg::*;
  logic clock_in, resetn_in, pll_locked_in, power_down_pin_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_out;
  logic reg_write, reg_read, reg_rvalid_out, duty_on, tick;
  logic [1:0] state_a, state_b;
  logic [2:0] div_code, phase_code;
  logic [23:0] rows [7];
  int fail_count, comparisons, ticks;
  adcpr_host i_adcpr_host (.clock_in(clock_in), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_write_out(reg_write), .reg_read_out(reg_read));
  adcpr_regs i_adcpr_regs (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .pll_locked_in(pll_locked_in), .power_down_pin_in(power_down_pin_in),
    .chan_a_power_state_out(state_a), .chan_b_power_state_out(state_b),
    .clock_duty_corrector_on_out(duty_on), .clock_div_code_out(div_code),
    .clock_phase_code_out(phase_code), .divided_clock_tick_out(tick));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_adcpr_host.access(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_adcpr_host.access(1'b0, a, 8'h00);
    #1;
    check({7'h00, reg_rvalid_out}, 8'h01);
    check(reg_rdata_out, exp);
  endtask
  // Shadow copies act only a fixed number of edges after the transfer strobe.
  task automatic commit();
    wr(OFF_TRANSFER, 8'h01);
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic results();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    resetn_in = 1'b0;
    pll_locked_in = 1'b0;
    power_down_pin_in = 1'b0;
    rows = '{24'h05FF03, 24'h09FF01, 24'h0AFF00, 24'h0BFF3F, 24'h0B2B2B, 24'h775500, 24'h08FE22};
    // Looked at after the first edge, since the time-zero reset edge may race the flops.
    @(posedge clock_in);
    #1;
    check({7'h00, duty_on}, 8'h01);
    check({6'h00, state_a}, 8'h00);
    check({5'h00, div_code}, 8'h00);
    @(posedge clock_in);
    resetn_in <= 1'b1;
    rd_chk(OFF_CHAN_SEL, RST_CHAN_SEL);
    rd_chk(OFF_POWER, RST_POWER);
    rd_chk(OFF_CLK_GLOBAL, RST_CLK_GLOBAL);
    rd_chk(OFF_PLL_STATUS, RST_PLL_STATUS);
    rd_chk(OFF_CLK_DIV, RST_CLK_DIV);
    rd_chk(OFF_TRANSFER, RST_TRANSFER);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd_chk(rows[i][23:16], rows[i][7:0]);
    end
    $display("row test done");
    wr(OFF_CLK_DIV, 8'h2B);
    wr(OFF_CLK_GLOBAL, 8'h00);
    check({5'h00, div_code}, 8'h00);
    commit();
    check({5'h00, div_code}, 8'h03);
    check({5'h00, phase_code}, 8'h05);
    check({7'h00, duty_on}, 8'h01);
    rd_chk(OFF_TRANSFER, 8'h00);
    repeat (8) @(posedge clock_in);
    ticks = 0;
    repeat (16) begin
      @(posedge clock_in);
      #1;
      ticks += tick;
    end
    check(8'(ticks), 8'h04);
    wr(OFF_CLK_DIV, 8'h00);
    commit();
    check({7'h00, duty_on}, 8'h00);
    $display("clock test done");
    wr(OFF_POWER, 8'h02);
    wr(OFF_CHAN_SEL, 8'h02);
    wr(OFF_POWER, 8'h21);
    rd_chk(OFF_POWER, 8'h21);
    wr(OFF_CHAN_SEL, 8'h03);
    rd_chk(OFF_POWER, 8'h02);
    commit();
    check({6'h00, state_a}, {6'h00, PM_STANDBY});
    check({6'h00, state_b}, {6'h00, PM_POWER_DOWN});
    @(posedge clock_in);
    power_down_pin_in <= 1'b1;
    pll_locked_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    check({6'h00, state_a}, {6'h00, PM_POWER_DOWN});
    check({6'h00, state_b}, {6'h00, PM_STANDBY});
    rd_chk(OFF_PLL_STATUS, 8'h80);
    @(posedge clock_in);
    power_down_pin_in <= 1'b0;
    wr(OFF_POWER, 8'h00);
    commit();
    check({6'h00, state_b}, {6'h00, PM_NORMAL});
    $display("power test done");
    // Leave channel select and the corrector away from their reset values first.
    wr(OFF_CHAN_SEL, 8'h01);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    @(posedge clock_in);
    resetn_in <= 1'b1;
    rd_chk(OFF_CHAN_SEL, RST_CHAN_SEL);
    check({7'h00, duty_on}, 8'h01);
    $display("second reset test done");
    results();
  end
endmodule
